// [common/timer_pkg.sv]
// Package for the 10-bit standard timer: register map, field layout,
// mode and output-function codes, control structs, period helpers.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package timer_pkg;

    typedef logic [31:0] word_t;
    typedef logic [7:0] addr_t;
    typedef logic [9:0] count_t;
    typedef logic [10:0] span_t;

    // ==========================================================
    // Register byte addresses
    localparam addr_t OFF_CNT_LO = 8'h00;
    localparam addr_t OFF_CNT_HI = 8'h04;
    localparam addr_t OFF_CMPA_LO = 8'h08;
    localparam addr_t OFF_CMPA_HI = 8'h0C;
    localparam addr_t OFF_CTRL0 = 8'h10;
    localparam addr_t OFF_CTRL1 = 8'h14;
    localparam addr_t OFF_FLAGS = 8'h18;

    // ==========================================================
    // Field codes
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAPT = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam logic [1:0] IO_00 = 2'h0;
    localparam logic [1:0] IO_01 = 2'h1;
    localparam logic [1:0] IO_10 = 2'h2;
    localparam logic [1:0] IO_11 = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    localparam int P_SHIFT = 7;
    localparam span_t FULL_SPAN = 11'h400;

    // Control word one, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] io;
        logic oc;
        logic pol;
        logic dpx;
        logic cclr;
    } ctrl1_t;

    // Control word zero: counter_on in bit 3, compare P in bits 2:0
    typedef struct packed {
        logic on;
        logic [2:0] compare_p_value;
    } ctrl0_t;

    localparam ctrl1_t CTRL1_RST = 8'h00;
    localparam ctrl0_t CTRL0_RST = 4'h0;

    // Length of a compare P span in timer clocks; code zero is full range
    function automatic span_t p_span(input logic [2:0] code);
        p_span = (code == 3'h0) ? FULL_SPAN :
                 span_t'({code, 7'h00});
    endfunction

    // Last count of a compare P span (code zero wraps to the maximum)
    function automatic count_t p_last(input logic [2:0] code);
        p_last = count_t'({code, 7'h00}) - count_t'(1);
    endfunction

endpackage

// [hw/standard_timer.sv]
// 10-bit standard timer: compare match output, timer/counter and
// edge-aligned PWM modes, with an AXI4-Lite register slave.
// Assumes timer_tick is a one-cycle enable from logic on aclk.
//
// Contract
// - Counter readable as low byte (bits 7:0) and high byte (bits 9:8).
// - Unused upper bits of both high-byte registers read as zero.
// - Compare A is 10 bits, written and read as low and high bytes.
// - Mode select 00 gives compare match output mode.
// - Clear select low: clear on P match or overflow; raise both flags.
// - Clear select high: clear on A match; only the A flag rises.
// - Compare mode pin changes only on an A match, never on P.
// - On A match pin goes high, low or toggles; field 00 no change.
// - Counter-on rising loads the pin with the output control level.
// - Mode 11 counts and flags like compare mode, pin not driven.
// - PWM needs mode 10 and output function 10; fixed-frequency waveform.
// - In PWM the swap bit picks period and duty comparators.
// - In PWM the clear select bit is ignored.
// - In PWM each A match and each P match raises its flag.
// - PWM output control picks polarity; function field may force level.
// - Output invert bit inverts the driven pin.
// - Swap clear: period 128 times P code, 1024 for zero; A sets duty.
// - Duty at or above period holds output active whole period.
// - Swap set: A sets period; duty 128 times P code, 1024 for zero.
// - PWM counting continues while the pin is forced with 00 or 01.
// - PWM function 00 inactive, 01 active, 10 waveform, 11 single pulse; here 11 is not built and rests inactive.
// - Compare P matched only against the counter's top three bits; here all ten bits match 128 times P code minus one.
// - Counter-on rise zeroes the counter; fall stops and keeps it.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module standard_timer
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Timer clock enable
    input wire logic timer_tick,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire timer_pkg::addr_t awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire timer_pkg::word_t wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire timer_pkg::addr_t araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output timer_pkg::word_t rdata,
    output logic [1:0] rresp,
    // Output pin
    output logic timer_output_pin,
    output logic timer_output_pin_oe_n
);
    import timer_pkg::*;

    // ==========================================================
    // Register bus slave
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic aw_full_r, w_full_r;
    logic [1:0] bresp_r, rresp_r;
    addr_t waddr_r;
    word_t wdata_r, rdata_r;
    logic wlane_r;

    wire aw_take = awvalid && awready_r;
    wire w_take = wvalid && wready_r;
    wire ar_take = arvalid && arready_r;
    wire do_write = aw_full_r && w_full_r && !bvalid_r;
    wire aw_full_nxt = aw_full_r ? !do_write : aw_take;
    wire w_full_nxt = w_full_r ? !do_write : w_take;
    // Only byte lane 0 carries register bits
    wire wr_en = do_write && wlane_r;

    wire wr_cmpa_lo = wr_en && (waddr_r == OFF_CMPA_LO);
    wire wr_cmpa_hi = wr_en && (waddr_r == OFF_CMPA_HI);
    wire wr_ctrl0 = wr_en && (waddr_r == OFF_CTRL0);
    wire wr_ctrl1 = wr_en && (waddr_r == OFF_CTRL1);
    wire wr_flags = wr_en && (waddr_r == OFF_FLAGS);
    wire w_mapped = (waddr_r == OFF_CNT_LO) || (waddr_r == OFF_CNT_HI) ||
                    (waddr_r == OFF_CMPA_LO) || (waddr_r == OFF_CMPA_HI) ||
                    (waddr_r == OFF_CTRL0) || (waddr_r == OFF_CTRL1) ||
                    (waddr_r == OFF_FLAGS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            waddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wlane_r <= 1'b0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awready_r <= !aw_full_nxt;
            wready_r <= !w_full_nxt;
            if (aw_take) begin
                waddr_r <= awaddr;
            end
            if (w_take) begin
                wdata_r <= wdata;
                wlane_r <= wstrb[0];
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= w_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Timer registers
    count_t cnt_r, cmpa_r;
    ctrl0_t ctrl0_r;
    ctrl1_t ctrl1_r;
    logic on_prev_r, flag_a_r, flag_p_r, cmp_level_r;
    logic pin_r, pin_oe_n_r;

    wire on_rise = ctrl0_r.on && !on_prev_r;
    wire is_cmp = (ctrl1_r.mode == MODE_CMP);
    wire is_timer = (ctrl1_r.mode == MODE_TIMER);
    wire is_pwm = (ctrl1_r.mode == MODE_PWM);
    // Capture mode is not built; the counter stands still there
    wire cnt_go = ctrl0_r.on && !on_rise && timer_tick &&
                  (ctrl1_r.mode != MODE_CAPT);
    wire a_hit = (cnt_r == cmpa_r);
    // Whole count against the last count of the P span; code 0 lands on the maximum
    wire p_hit = (cnt_r == p_last(ctrl0_r.compare_p_value));
    wire span_t period_p = p_span(ctrl0_r.compare_p_value);
    // In PWM the swap bit alone chooses the clearing comparator
    wire pwm_clr = ctrl1_r.dpx ? a_hit : p_hit;
    wire cmp_clr = ctrl1_r.cclr ? a_hit : p_hit;
    wire cnt_clr = is_pwm ? pwm_clr : cmp_clr;
    wire set_a = cnt_go && a_hit;
    wire set_p = cnt_go && p_hit && (is_pwm || !ctrl1_r.cclr);

    // PWM: active from clear until count reaches duty
    wire span_t duty = ctrl1_r.dpx ? period_p : span_t'(cmpa_r);
    // Duty at or past the period never ends inside it
    wire pwm_on = (span_t'(cnt_r) < duty);
    wire act_lvl = ctrl1_r.oc;
    // Single pulse is not built; code 11 rests inactive
    wire pwm_lvl = (ctrl1_r.io == IO_01) ? act_lvl :
                   (ctrl1_r.io == IO_10 && pwm_on) ? act_lvl :
                   !act_lvl;
    wire cmp_nxt = (ctrl1_r.io == IO_01) ? 1'b0 :
                   (ctrl1_r.io == IO_10) ? 1'b1 :
                   (ctrl1_r.io == IO_11) ? !cmp_level_r :
                   cmp_level_r;
    wire drive = is_pwm || is_cmp;
    wire pin_nxt = drive && ((is_pwm ? pwm_lvl : cmp_level_r) ^
                   ctrl1_r.pol);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 10'h000;
            on_prev_r <= 1'b0;
            cmp_level_r <= 1'b0;
        end else begin
            on_prev_r <= ctrl0_r.on;
            if (on_rise) begin
                cnt_r <= 10'h000;
                cmp_level_r <= ctrl1_r.oc;
            end else if (cnt_go) begin
                cnt_r <= cnt_clr ? 10'h000 : cnt_r + 10'h001;
                if (is_cmp && a_hit) begin
                    cmp_level_r <= cmp_nxt;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmpa_r <= 10'h000;
            ctrl0_r <= CTRL0_RST;
            ctrl1_r <= CTRL1_RST;
        end else begin
            if (wr_cmpa_lo) begin
                cmpa_r[7:0] <= wdata_r[7:0];
            end
            if (wr_cmpa_hi) begin
                cmpa_r[9:8] <= wdata_r[1:0];
            end
            if (wr_ctrl0) begin
                ctrl0_r <= wdata_r[3:0];
            end
            if (wr_ctrl1) begin
                ctrl1_r <= wdata_r[7:0];
            end
        end
    end

    // Flags clear by writing one; a same-cycle event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_a_r <= 1'b0;
            flag_p_r <= 1'b0;
            pin_r <= 1'b0;
            pin_oe_n_r <= 1'b1;
        end else begin
            flag_a_r <= set_a ||
                (flag_a_r && !(wr_flags && wdata_r[FLAG_A_BIT]));
            flag_p_r <= set_p ||
                (flag_p_r && !(wr_flags && wdata_r[FLAG_P_BIT]));
            pin_r <= pin_nxt;
            pin_oe_n_r <= !drive;
        end
    end

    // ==========================================================
    // Read path
    word_t rd_word;
    logic rd_ok;
    always_comb begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        case (araddr)
            OFF_CNT_LO: rd_word[7:0] = cnt_r[7:0];
            OFF_CNT_HI: rd_word[1:0] = cnt_r[9:8];
            OFF_CMPA_LO: rd_word[7:0] = cmpa_r[7:0];
            OFF_CMPA_HI: rd_word[1:0] = cmpa_r[9:8];
            OFF_CTRL0: rd_word[3:0] = ctrl0_r;
            OFF_CTRL1: rd_word[7:0] = ctrl1_r;
            OFF_FLAGS: rd_word[1:0] = {flag_p_r, flag_a_r};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign timer_output_pin = pin_r;
    assign timer_output_pin_oe_n = pin_oe_n_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_hi_zero;
        ar_take && (araddr == OFF_CNT_HI) |=> rdata_r[31:2] == 30'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("count high byte upper bits not zero");

    property p_cnt_read;
        ar_take && (araddr == OFF_CNT_LO) |=>
            rvalid_r && rdata_r[7:0] == $past(cnt_r[7:0]);
    endproperty
    a_cnt_read: assert property (p_cnt_read)
        else $error("count low byte read mismatch");

    property p_on_rise;
        on_rise |=> cnt_r == 10'h000 && cmp_level_r == $past(ctrl1_r.oc);
    endproperty
    a_on_rise: assert property (p_on_rise)
        else $error("counter start did not reset count and level");

    property p_no_pflag;
        !is_pwm && ctrl1_r.cclr && !flag_p_r && !wr_ctrl1 |=>
            !flag_p_r;
    endproperty
    a_no_pflag: assert property (p_no_pflag)
        else $error("P flag raised with clear select high");

    property p_cmp_hold;
        !on_rise && !(cnt_go && a_hit) |=> $stable(cmp_level_r);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold)
        else $error("compare level moved without an A match");

    property p_toggle;
        is_cmp && set_a && !on_rise && ctrl1_r.io == IO_11 |=>
            cmp_level_r != $past(cmp_level_r);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle on A match did not happen");

    property p_timer_idle;
        is_timer |=> timer_output_pin_oe_n && !timer_output_pin;
    endproperty
    a_timer_idle: assert property (p_timer_idle)
        else $error("pin driven in timer mode");

    property p_full_duty;
        is_pwm && ctrl1_r.io == IO_10 && !ctrl1_r.dpx &&
            span_t'(cmpa_r) >= period_p |=>
            pin_r == ($past(ctrl1_r.oc) ^ $past(ctrl1_r.pol));
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("full duty not held active");

    property p_count_step;
        cnt_go && !cnt_clr |=> cnt_r == $past(cnt_r) + 10'h001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step on tick");

    property p_stop_keep;
        !ctrl0_r.on && !on_rise |=> $stable(cnt_r);
    endproperty
    a_stop_keep: assert property (p_stop_keep)
        else $error("stopped counter changed");

    property p_pwm_flags;
        is_pwm && cnt_go && (a_hit || p_hit) |=>
            (flag_a_r || !$past(a_hit)) && (flag_p_r || !$past(p_hit));
    endproperty
    a_pwm_flags: assert property (p_pwm_flags)
        else $error("PWM match flags not raised");

endmodule

`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the 10-bit standard timer.
// Assumes timer_pkg and standard_timer compiled first; bench drives ticks.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import timer_pkg::*;

    // ==========================================================
    // Stimulus and observation signals
    logic aclk, aresetn, timer_tick;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    addr_t awaddr, araddr;
    word_t wdata, rdata, rd_word;
    logic [1:0] bresp, rresp, last_resp;
    logic timer_output_pin, timer_output_pin_oe_n;
    int bad_count = 0;
    int num_checks = 0;
    int highs;

    standard_timer u_dut (
        .aclk(aclk), .aresetn(aresetn), .timer_tick(timer_tick),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .timer_output_pin(timer_output_pin),
        .timer_output_pin_oe_n(timer_output_pin_oe_n)
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // ==========================================================
    // Reporting
    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic hang(input string what);
        bad_count++;
        $display("unexpected %s: expected answer seen none", what);
        print_verdict();
    endtask

    // ==========================================================
    // AXI4-Lite master; every wait is bounded
    task automatic wr(input addr_t a, input word_t d);
        int n;
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (!(aw_done && w_done)) hang("write accept");
        for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge aclk);
        if (bvalid !== 1'b1) hang("write response");
        last_resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input addr_t a);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        // Let the request reach the slave before arready is judged
        @(posedge aclk);
        for (n = 0; n < 50 && arready !== 1'b1; n++) @(posedge aclk);
        if (arready !== 1'b1) hang("read accept");
        arvalid <= 1'b0;
        @(posedge aclk);
        for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(posedge aclk);
        if (rvalid !== 1'b1) hang("read data");
        rd_word = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask

    // ==========================================================
    // Timer helpers
    function automatic word_t c1(input logic [1:0] mode,
            input logic [1:0] io, input logic oc, input logic pol,
            input logic dpx, input logic cclr);
        c1 = word_t'({mode, io, oc, pol, dpx, cclr});
    endfunction

    // Stop, program, clear flags, then start with the given compare P
    task automatic setup(input word_t c1v, input logic [9:0] a,
                         input logic [2:0] p);
        wr(OFF_CTRL0, 32'h0);
        wr(OFF_CTRL1, c1v);
        wr(OFF_CMPA_LO, word_t'(a[7:0]));
        wr(OFF_CMPA_HI, word_t'(a[9:8]));
        wr(OFF_FLAGS, 32'h3);
        wr(OFF_CTRL0, word_t'({1'b1, p}));
    endtask

    // Pin is sampled after each tick has settled through its register
    task automatic ticks(input int n);
        highs = 0;
        repeat (n) begin
            @(posedge aclk);
            timer_tick <= 1'b1;
            @(posedge aclk);
            timer_tick <= 1'b0;
            @(posedge aclk);
            #1;
            if (timer_output_pin === 1'b1) highs++;
        end
    endtask

    task automatic check_count(input int exp);
        rd(OFF_CNT_LO);
        check("count low", rd_word, word_t'(exp & 8'hFF));
        rd(OFF_CNT_HI);
        check("count high", rd_word, word_t'(exp >> 8));
    endtask

    task automatic pwm(input word_t c1v, input logic [9:0] a,
                       input logic [2:0] p, input int n, input int exp);
        setup(c1v, a, p);
        ticks(n);
        check("pwm active samples", 32'(highs), 32'(exp));
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        aresetn = 1'b0;
        timer_tick = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(addr_t'(i * 4));
            check("reset value", rd_word, 32'h0);
        end
        rd(8'h1C);
        check("unmapped read data", rd_word, 32'h0);
        check("unmapped read resp", 32'(last_resp), 32'(RESP_SLVERR));
        wr(8'h1C, 32'hFF);
        check("unmapped write resp", 32'(last_resp), 32'(RESP_SLVERR));
        wr(OFF_CMPA_LO, 32'hA5);
        wr(OFF_CMPA_HI, 32'hFF);
        rd(OFF_CMPA_LO);
        check("compare a low", rd_word, 32'hA5);
        rd(OFF_CMPA_HI);
        check("compare a high", rd_word, 32'h3);
        // Timer mode: count, stop and keep, restart from zero
        setup(c1(MODE_TIMER, IO_00, 1'b0, 1'b0, 1'b0, 1'b0), 10'h3FF, 3'h0);
        check("oe_n timer mode", 32'(timer_output_pin_oe_n), 32'h1);
        ticks(300);
        check_count(300);
        wr(OFF_CTRL0, 32'h0);
        ticks(5);
        check_count(300);
        wr(OFF_CTRL0, 32'h8);
        check_count(0);
        // Compare mode, clear on P match at count 127, the last count for P code 1
        setup(c1(MODE_CMP, IO_00, 1'b0, 1'b0, 1'b0, 1'b0), 10'd5, 3'h1);
        ticks(130);
        check_count(2);
        rd(OFF_FLAGS);
        check("flags p clear", rd_word, 32'h3);
        wr(OFF_FLAGS, 32'h3);
        rd(OFF_FLAGS);
        check("flags after clear", rd_word, 32'h0);
        // Clear on A match; count passes the P point without a P flag
        setup(c1(MODE_CMP, IO_00, 1'b0, 1'b0, 1'b0, 1'b1), 10'd200, 3'h1);
        ticks(210);
        check_count(9);
        rd(OFF_FLAGS);
        check("flags a clear", rd_word, 32'h1);
        // Pin action for each output function code
        for (int i = 0; i < 4; i++) begin
            logic [1:0] io;
            logic oc;
            logic exp_pin;
            io = 2'(i);
            oc = ~io[1];
            exp_pin = (io == IO_00) ? oc : (io == IO_01) ? 1'b0 :
                      (io == IO_10) ? 1'b1 : ~oc;
            setup(c1(MODE_CMP, io, oc, 1'b0, 1'b0, 1'b1), 10'd9, 3'h1);
            repeat (3) @(posedge aclk);
            #1;
            check("pin initial", 32'(timer_output_pin), 32'(oc));
            check("oe_n compare", 32'(timer_output_pin_oe_n), 32'h0);
            ticks(10);
            check("pin on match", 32'(timer_output_pin), 32'(exp_pin));
        end
        // PWM, first case with clear select set to show that it is ignored
        pwm(c1(MODE_PWM, IO_10, 1'b1, 1'b0, 1'b0, 1'b1), 10'd32, 3'h1,
            128, 32);
        rd(OFF_FLAGS);
        check("pwm flags", rd_word, 32'h3);
        pwm(c1(MODE_PWM, IO_10, 1'b1, 1'b0, 1'b0, 1'b0), 10'd32, 3'h2,
            256, 32);
        pwm(c1(MODE_PWM, IO_10, 1'b1, 1'b0, 1'b0, 1'b0), 10'd200, 3'h1,
            128, 128);
        pwm(c1(MODE_PWM, IO_10, 1'b1, 1'b0, 1'b1, 1'b0), 10'd299, 3'h1,
            300, 128);
        pwm(c1(MODE_PWM, IO_10, 1'b1, 1'b1, 1'b0, 1'b0), 10'd32, 3'h1,
            128, 96);
        pwm(c1(MODE_PWM, IO_10, 1'b0, 1'b0, 1'b0, 1'b0), 10'd32, 3'h1,
            128, 96);
        pwm(c1(MODE_PWM, IO_00, 1'b1, 1'b0, 1'b0, 1'b0), 10'd32, 3'h1,
            128, 0);
        rd(OFF_FLAGS);
        check("forced pwm flags", rd_word, 32'h3);
        pwm(c1(MODE_PWM, IO_01, 1'b1, 1'b0, 1'b0, 1'b0), 10'd32, 3'h1,
            128, 128);
        print_verdict();
    end
endmodule

`default_nettype wire
